// ---- design/blf_regs.vh ----
// Purpose: Constants for the bus-loss fail-safe sequencer
// Assumes: Included by every design file of the block
// Notes:   Counts are in bus frame periods unless named otherwise
`ifndef BLF_REGS_VH
`define BLF_REGS_VH

// ==========================================================
// Loss detection
`define BLF_LOSS_FRAMES     25000
`define BLF_CNT_W           15

// ==========================================================
// Secure position
`define BLF_POS_W           11
`define BLF_SEC_NONE        11'h400
`define BLF_SEC_DIR_BIT     10
`define BLF_HALF_RANGE      16'h0400

// ==========================================================
// Interrupt status and mask bit positions
`define BLF_IRQ_LOSS        0
`define BLF_IRQ_DONE        1
`define BLF_IRQ_W           2

// ==========================================================
// Register offsets
`define BLF_REG_STATUS      4'h0
`define BLF_REG_MASK        4'h1
`define BLF_REG_STATE       4'h2
`define BLF_REG_SECURE_POSITION      4'h3
`define BLF_REG_CTRL        4'h4

// ==========================================================
// Reset values
`define BLF_MASK_RST        2'h0
`define BLF_CTRL_RST        3'h0

`endif

// ---- design/blf_loss_timer.v ----
// Purpose: Counts silent frame periods and flags bus loss
// Assumes: frameTick is one pulse per nominal frame period
// Notes:   Any valid frame restarts the count
`timescale 1ns/10ps
`default_nettype none
`include "blf_regs.vh"

module blf_loss_timer #(
  parameter LOSS_FRAMES = `BLF_LOSS_FRAMES,
  parameter CNT_W       = `BLF_CNT_W
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             clkEn,
  // Bus activity
  input  wire             frameTick,
  input  wire             frameValid,
  // Result
  output reg              busLost
);

  reg [CNT_W-1:0] silentCount;

  // ==========================================================
  // Silence counter
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      silentCount <= {CNT_W{1'b0}};
      busLost     <= 1'b0;
    end else if (clkEn) begin
      if (frameValid) begin
        silentCount <= {CNT_W{1'b0}};
        busLost     <= 1'b0;
      end else if (frameTick && !busLost) begin
        if (silentCount == LOSS_FRAMES[CNT_W-1:0] - 1'b1) begin
          busLost <= 1'b1;
        end
        silentCount <= silentCount + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/blf_irq.v ----
// Purpose: Sticky event status with mask and one level interrupt
// Assumes: Software clears a bit by writing one
// Notes:   A set in the clearing cycle wins
`timescale 1ns/10ps
`default_nettype none
`include "blf_regs.vh"

module blf_irq #(
  parameter W = `BLF_IRQ_W
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire         clkEn,
  // Events and software access
  input  wire [W-1:0] eventSet,
  input  wire [W-1:0] clearBits,
  input  wire         maskWrite,
  input  wire [W-1:0] maskData,
  // State
  output reg  [W-1:0] status,
  output reg  [W-1:0] mask,
  output wire         irq
);

  // ==========================================================
  // Sticky bits, set over clear
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= {W{1'b0}};
      mask   <= `BLF_MASK_RST;
    end else if (clkEn) begin
      status <= (status & ~clearBits) | eventSet;
      if (maskWrite) begin
        mask <= maskData;
      end
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

// ---- design/blf_failsafe_seq.v ----
// Purpose: Bus-loss fail-safe sequencer of a stepper positioner
// Assumes: Motion engine reports busy and stall; OTP bits are static
// Notes:   Stop and sleep are terminal until a frame or reset arrives
`timescale 1ns/10ps
`default_nettype none
`include "blf_regs.vh"

// Function
// - Flag loss after 25000 silent frames
// - Action from sleep, failsafe and loss kind
// - Sleep bit permits sleep, default disabled
// - Failsafe bit zero starts no motion
// - Motion needs failsafe; 0x400 blocks all but the reference run
// - Failsafe off: sleep or stop
// - Normal loss, position 0x400: sleep or stop
// - Normal loss: copy secure to target
// - Normal loss uses RAM secure position
// - Normal loss: full 11-bit position
// - Floating address pin acts as loss
// - Power-on loss: negative half-range referencing run
// - End stop clears actual position
// - Direction invert sets first move direction
// - Referenced, position 0x400: sleep or stop
// - Second move, direction bit10 xor invert
// - Power-on loss: 9-bit secure position
module blf_failsafe_seq #(
  parameter LOSS_FRAMES = `BLF_LOSS_FRAMES,
  parameter POS_W       = `BLF_POS_W
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             clkEn,
  // Bus activity
  input  wire             frameTick,
  input  wire             frameValid,
  input  wire             addrPinFloat,
  // OTP configuration
  input  wire             otpSleepEn,
  input  wire             otpFailSafe,
  input  wire             otpDirInvert,
  input  wire [POS_W-1:0] otpSecurePosition,
  // RAM secure position update from the bus
  input  wire             securePositionWrite,
  input  wire [POS_W-1:0] securePositionData,
  // Motion engine
  input  wire             motionBusy,
  input  wire             stallDetected,
  output reg              moveStart,
  output reg  [15:0]      targetPosition,
  output reg              moveDir,
  output reg              useOtpParams,
  output reg              actualPositionClear,
  // Power state
  output reg              stopState,
  output reg              sleepState,
  // Register port
  input  wire [3:0]       regAddr,
  input  wire [15:0]      regWdata,
  input  wire             regWrite,
  input  wire             regRead,
  output reg  [15:0]      regRdata,
  // Interrupt
  output wire             irq
);

  // ==========================================================
  // States
  localparam ST_IDLE  = 3'h0;
  localparam ST_ABS   = 3'h1;
  localparam ST_REF1  = 3'h2;
  localparam ST_REF2  = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_STOP  = 3'h5;
  localparam ST_SLEEP = 3'h6;

  reg  [2:0]       state;
  reg  [2:0]       next_state;
  reg  [POS_W-1:0] securePosition;
  reg              frameSeen;
  reg              lossLatched;
  reg              lossPowerOn;
  reg              busyStarted;
  reg              swForceLoss;
  reg              swSleepOverride;
  reg              swHold;
  reg              doneEvent;
  wire             busLost;
  wire             lossEvent;
  wire             lossNow;
  wire             effSleep;
  wire [1:0]       irqStatus;
  wire [1:0]       irqMask;
  wire [POS_W-1:0] securePos9;

  // Reduced resolution copy used after power-on loss
  assign securePos9 = {securePosition[POS_W-1:2], 2'b00};
  // Sleep defaults off; software may only veto it
  assign effSleep = otpSleepEn & ~swSleepOverride;

  // ==========================================================
  // Loss detection
  blf_loss_timer #(
    .LOSS_FRAMES (LOSS_FRAMES),
    .CNT_W       (`BLF_CNT_W)
  ) u_timer (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .frameTick  (frameTick),
    .frameValid (frameValid),
    .busLost    (busLost)
  );

  // Floating address pin is handled exactly like silence
  assign lossNow   = busLost | addrPinFloat | swForceLoss;
  assign lossEvent = lossNow & ~lossLatched;

  // ==========================================================
  // Secure position is a signed word with an invalid marker
  function isNone;
    input [POS_W-1:0] pos;
    begin
      isNone = (pos == `BLF_SEC_NONE);
    end
  endfunction

  // Either 0x400 marker or a position
  function [15:0] extendPos;
    input [POS_W-1:0] pos;
    begin
      extendPos = {{(16-POS_W){pos[POS_W-1]}}, pos};
    end
  endfunction

  // Terminal state chosen by the sleep permission
  function [2:0] restState;
    input sleepOk;
    begin
      restState = sleepOk ? ST_SLEEP : ST_STOP;
    end
  endfunction

  // ==========================================================
  // Loss bookkeeping
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameSeen   <= 1'b0;
      lossLatched <= 1'b0;
      lossPowerOn <= 1'b0;
      securePosition <= `BLF_SEC_NONE;
    end else if (clkEn) begin
      if (frameValid) begin
        frameSeen <= 1'b1;
      end
      if (lossEvent) begin
        lossLatched <= 1'b1;
        lossPowerOn <= ~frameSeen;
      end else if (!lossNow && state == ST_IDLE) begin
        lossLatched <= 1'b0;
      end
      // RAM copy follows OTP until the first frame or a loss; a master write wins only in its own cycle
      if (securePositionWrite) begin
        securePosition <= securePositionData;
      end else if (!frameSeen && !lossLatched) begin
        securePosition <= otpSecurePosition;
      end
    end
  end

  // ==========================================================
  // Sequencer decisions
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (lossEvent && !swHold) begin
          if (!otpFailSafe) begin
            next_state = restState(effSleep);
          end else if (frameSeen) begin
            if (isNone(securePosition)) begin
              next_state = restState(effSleep);
            end else begin
              next_state = ST_ABS;
            end
          end else begin
            next_state = ST_REF1;
          end
        end
      end
      ST_ABS: begin
        // Busy must be seen first, so a late engine start is not missed
        if (busyStarted && !motionBusy) begin
          next_state = restState(effSleep);
        end
      end
      ST_REF1: begin
        if (stallDetected) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (isNone(securePosition)) begin
          next_state = restState(effSleep);
        end else begin
          next_state = ST_REF2;
        end
      end
      ST_REF2: begin
        if (busyStarted && !motionBusy) begin
          next_state = restState(effSleep);
        end
      end
      ST_STOP: begin
        // Silence keeps the state; only a frame wakes it
        if (frameValid) begin
          next_state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (frameValid) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Motion commands and outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state               <= ST_IDLE;
      moveStart           <= 1'b0;
      targetPosition      <= 16'h0000;
      moveDir             <= 1'b0;
      useOtpParams        <= 1'b0;
      actualPositionClear <= 1'b0;
      stopState           <= 1'b0;
      sleepState          <= 1'b0;
      busyStarted         <= 1'b0;
      doneEvent           <= 1'b0;
    end else if (clkEn) begin
      state               <= next_state;
      moveStart           <= 1'b0;
      actualPositionClear <= 1'b0;
      doneEvent           <= 1'b0;
      if (motionBusy) begin
        busyStarted <= 1'b1;
      end
      if (next_state != state) begin
        busyStarted <= 1'b0;
        stopState   <= (next_state == ST_STOP);
        sleepState  <= (next_state == ST_SLEEP);
        if (next_state == ST_STOP || next_state == ST_SLEEP) begin
          doneEvent <= 1'b1;
        end
        case (next_state)
          ST_ABS: begin
            // Full resolution absolute move, referenced already
            targetPosition <= extendPos(securePosition);
            moveDir        <= 1'b0;
            useOtpParams   <= 1'b0;
            moveStart      <= 1'b1;
          end
          ST_REF1: begin
            // Negative run over half range; stall ends it
            targetPosition <= 16'h0000 - `BLF_HALF_RANGE;
            moveDir        <= otpDirInvert;
            useOtpParams   <= 1'b1;
            moveStart      <= 1'b1;
          end
          ST_WAIT: begin
            actualPositionClear <= 1'b1;
          end
          ST_REF2: begin
            targetPosition <= extendPos(securePos9);
            moveDir        <= securePosition[`BLF_SEC_DIR_BIT] ^ otpDirInvert;
            useOtpParams   <= 1'b1;
            moveStart      <= 1'b1;
          end
          default: begin
            moveStart <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Interrupt block
  blf_irq #(
    .W (`BLF_IRQ_W)
  ) u_irq (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .eventSet  ({doneEvent, lossEvent}),
    .clearBits ((regWrite && regAddr == `BLF_REG_STATUS) ? regWdata[1:0] : 2'b00),
    .maskWrite (regWrite && regAddr == `BLF_REG_MASK),
    .maskData  (regWdata[1:0]),
    .status    (irqStatus),
    .mask      (irqMask),
    .irq       (irq)
  );

  // ==========================================================
  // Register port
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swForceLoss     <= 1'b0;
      swSleepOverride <= 1'b0;
      swHold          <= 1'b0;
      regRdata        <= 16'h0000;
    end else if (clkEn) begin
      if (regWrite && regAddr == `BLF_REG_CTRL) begin
        swForceLoss     <= regWdata[0];
        swSleepOverride <= regWdata[1];
        swHold          <= regWdata[2];
      end
      regRdata <= 16'h0000;
      if (regRead) begin
        case (regAddr)
          `BLF_REG_STATUS: regRdata <= {14'h0000, irqStatus};
          `BLF_REG_MASK:   regRdata <= {14'h0000, irqMask};
          `BLF_REG_STATE:  regRdata <= {9'h000, lossPowerOn, lossLatched, frameSeen, busLost,
                                        state};
          `BLF_REG_SECURE_POSITION: regRdata <= {5'h00, securePosition};
          `BLF_REG_CTRL:   regRdata <= {13'h0000, swHold, swSleepOverride, swForceLoss};
          default:         regRdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- test/blf_failsafe_props.sv ----
// Purpose: Port assertions for the bus-loss fail-safe sequencer
// Assumes: Bound to blf_failsafe_seq; clkEn is low only while idle
// Notes:   Sees outputs and the inputs that cause them only
`timescale 1ns/10ps
`default_nettype none
module blf_failsafe_props #(
  parameter LOSS_FRAMES = 25000
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Causes
  input wire logic        otpSleepEn,
  input wire logic        otpFailSafe,
  input wire logic        otpDirInvert,
  input wire logic        stallDetected,
  input wire logic        frameValid,
  input wire logic        regRead,
  // Effects
  input wire logic        moveStart,
  input wire logic [15:0] targetPosition,
  input wire logic        moveDir,
  input wire logic        useOtpParams,
  input wire logic        actualPositionClear,
  input wire logic        stopState,
  input wire logic        sleepState,
  input wire logic [15:0] regRdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Motion
  property p_noMove; !otpFailSafe |-> !moveStart; endproperty
  a_noMove: assert property (p_noMove) else $error("move without failsafe");
  property p_absDir; moveStart && !useOtpParams |-> !moveDir && otpFailSafe; endproperty
  a_absDir: assert property (p_absDir) else $error("abs move fields");
  property p_refDir;
    moveStart && targetPosition == 16'hfc00 |-> moveDir == otpDirInvert && useOtpParams;
  endproperty
  a_refDir: assert property (p_refDir) else $error("first ref move fields");
  property p_ref2Lsb;
    moveStart && useOtpParams && targetPosition != 16'hfc00 |-> targetPosition[1:0] == 2'h0;
  endproperty
  a_ref2Lsb: assert property (p_ref2Lsb) else $error("second move resolution");
  property p_startPulse; moveStart |=> !moveStart; endproperty
  a_startPulse: assert property (p_startPulse) else $error("move start too long");
  property p_clear;
    actualPositionClear |-> $past(stallDetected) ##1 !actualPositionClear;
  endproperty
  a_clear: assert property (p_clear) else $error("position clear without stall");
  // ==========================================================
  // Power state and register port
  property p_excl; !(stopState && sleepState); endproperty
  a_excl: assert property (p_excl) else $error("stop and sleep together");
  property p_sleep; sleepState |-> otpSleepEn; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep while disabled");
  property p_exit;
    (stopState || sleepState) && frameValid |=> !stopState && !sleepState;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit on frame");
  property p_rdIdle; !regRead |=> regRdata == 16'h0; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ---- test/blf_lin_master.sv ----
// Purpose: Behavioural bus master that makes frame ticks and frames
// Assumes: One tick or frame pulse per two core clocks
// Notes:   Silence is just ticks without a frame
`timescale 1ns/10ps
`default_nettype none
module blf_lin_master (
  // Clock
  input  wire logic core_clk,
  // Bus activity
  output var  logic frameTick,
  output var  logic frameValid
);
  initial begin
    frameTick = 1'b0;
    frameValid = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      frameTick <= 1'b1;
      @(posedge core_clk);
      frameTick <= 1'b0;
    end
  endtask
  task automatic frame();
    @(posedge core_clk);
    frameValid <= 1'b1;
    @(posedge core_clk);
    frameValid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/test_bus_loss_failsafe_seq.sv ----
// Purpose: Self-checking bench of the bus-loss fail-safe sequencer
// Assumes: Loss count shortened to four frames
// Notes:   Motion engine is played by the bench
`timescale 1ns/10ps
`default_nettype none
module test_bus_loss_failsafe_seq;
  logic        core_clk, rst_n, addrPinFloat, otpSleepEn, otpFailSafe, otpDirInvert;
  logic [10:0] otpSecurePosition, securePositionData;
  logic        securePositionWrite, motionBusy, stallDetected, regWrite, regRead;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata, targetPosition, rd;
  logic        frameTick, frameValid, moveStart, moveDir, useOtpParams;
  logic        actualPositionClear, stopState, sleepState, irq, clkEn;
  int          n_mismatch, samples_checked;
  blf_lin_master lin_u (.core_clk(core_clk), .frameTick(frameTick), .frameValid(frameValid));
  blf_failsafe_seq #(.LOSS_FRAMES(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .frameTick(frameTick), .frameValid(frameValid), .addrPinFloat(addrPinFloat),
    .otpSleepEn(otpSleepEn), .otpFailSafe(otpFailSafe), .otpDirInvert(otpDirInvert),
    .otpSecurePosition(otpSecurePosition), .securePositionWrite(securePositionWrite),
    .securePositionData(securePositionData), .motionBusy(motionBusy),
    .stallDetected(stallDetected), .moveStart(moveStart), .targetPosition(targetPosition),
    .moveDir(moveDir), .useOtpParams(useOtpParams), .actualPositionClear(actualPositionClear),
    .stopState(stopState), .sleepState(sleepState), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regWr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [3:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    rd = regRdata;
  endtask
  // Bounded wait for a move start or a terminal state
  task automatic waitAct();
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (moveStart || stopState || sleepState) break;
    end
  endtask
  task automatic runMove();
    @(posedge core_clk);
    motionBusy <= 1'b1;
    repeat (3) @(posedge core_clk);
    motionBusy <= 1'b0;
    waitAct();
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    regRd(4'h1);
    chk("mask", rd, 16'h0000);
    regRd(4'h4);
    chk("ctrl", rd, 16'h0000);
    regRd(4'h2);
    chk("state", rd, 16'h0000);
    regRd(4'hf);
    chk("unmapped", rd, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_powerOn();
    regWr(4'h1, 16'h0003);
    lin_u.tick(3);
    @(negedge core_clk);
    chk("early", {15'h0, moveStart | stopState}, 16'h0000);
    lin_u.tick(1);
    waitAct();
    chk("ref1 start", {15'h0, moveStart}, 16'h0001);
    chk("ref1 target", targetPosition, 16'hfc00);
    chk("ref1 dir", {14'h0, moveDir, useOtpParams}, 16'h0003);
    @(posedge core_clk);
    motionBusy <= 1'b1;
    stallDetected <= 1'b1;
    @(posedge core_clk);
    stallDetected <= 1'b0;
    @(negedge core_clk);
    chk("pos clear", {15'h0, actualPositionClear}, 16'h0001);
    waitAct();
    chk("ref2 target", targetPosition, 16'h0120);
    chk("ref2 dir", {14'h0, moveDir, moveStart}, 16'h0003);
    runMove();
    chk("stop", {14'h0, sleepState, stopState}, 16'h0001);
    regRd(4'h0);
    chk("status", rd, 16'h0003);
    chk("irq", {15'h0, irq}, 16'h0001);
    regWr(4'h0, 16'h0003);
    @(negedge core_clk);
    chk("irq clr", {15'h0, irq}, 16'h0000);
    $display("test power-on loss done");
  endtask
  task automatic t_normal();
    lin_u.frame();
    @(negedge core_clk);
    chk("exit", {15'h0, stopState}, 16'h0000);
    @(posedge core_clk);
    securePositionData <= 11'h7f3;
    securePositionWrite <= 1'b1;
    @(posedge core_clk);
    securePositionWrite <= 1'b0;
    regRd(4'h3);
    chk("secure_position", rd, 16'h07f3);
    @(posedge core_clk);
    otpSleepEn <= 1'b1;
    lin_u.tick(3);
    lin_u.frame();
    lin_u.tick(3);
    regRd(4'h2);
    chk("no loss", rd & 16'h000f, 16'h0000);
    lin_u.tick(1);
    waitAct();
    chk("abs target", targetPosition, 16'hfff3);
    chk("abs mode", {14'h0, moveStart, useOtpParams}, 16'h0002);
    runMove();
    chk("sleep", {14'h0, sleepState, stopState}, 16'h0002);
    lin_u.frame();
    $display("test normal loss done");
  endtask
  task automatic t_noMotion();
    for (int i = 0; i < 2; i++) begin
      otpFailSafe <= (i == 0);
      otpSleepEn <= (i == 1);
      securePositionData <= (i == 0) ? 11'h400 : 11'h123;
      securePositionWrite <= 1'b1;
      @(posedge core_clk);
      securePositionWrite <= 1'b0;
      if (i == 0) addrPinFloat <= 1'b1;
      else lin_u.tick(4);
      waitAct();
      chk("no move", {14'h0, moveStart, stopState | sleepState}, 16'h0001);
      chk("kind", {15'h0, sleepState}, {15'h0, i[0]});
      @(posedge core_clk);
      addrPinFloat <= 1'b0;
      lin_u.frame();
    end
    $display("test no motion done");
  endtask
  // Second reset in mid-run, frozen clock enable, no second move
  task automatic t_refNone();
    @(posedge core_clk);
    rst_n <= 1'b0;
    otpSecurePosition <= 11'h400;
    otpSleepEn <= 1'b0;
    otpFailSafe <= 1'b1;
    @(posedge core_clk);
    rst_n <= 1'b1;
    clkEn <= 1'b0;
    lin_u.tick(4);
    @(posedge core_clk);
    clkEn <= 1'b1;
    regRd(4'h2);
    chk("frozen", rd, 16'h0000);
    lin_u.tick(4);
    waitAct();
    chk("ref1 again", {15'h0, moveStart}, 16'h0001);
    chk("ref1 dir0", {14'h0, moveDir, useOtpParams}, 16'h0001);
    @(posedge core_clk);
    stallDetected <= 1'b1;
    @(posedge core_clk);
    stallDetected <= 1'b0;
    waitAct();
    chk("no second", {14'h0, moveStart, stopState}, 16'h0001);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    lin_u.frame();
    $display("test referencing without second move done");
  endtask
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    {addrPinFloat, otpSleepEn, otpDirInvert, securePositionWrite} = 4'h0;
    {motionBusy, stallDetected, regWrite, regRead} = 4'h0;
    otpFailSafe = 1'b1;
    otpDirInvert = 1'b1;
    otpSecurePosition = 11'h123;
    securePositionData = 11'h000;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_powerOn();
    @(posedge core_clk);
    otpDirInvert <= 1'b0;
    t_normal();
    t_noMotion();
    t_refNone();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
endmodule
bind blf_failsafe_seq blf_failsafe_props #(.LOSS_FRAMES(LOSS_FRAMES)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .otpSleepEn(otpSleepEn), .otpFailSafe(otpFailSafe),
  .otpDirInvert(otpDirInvert), .stallDetected(stallDetected), .frameValid(frameValid),
  .regRead(regRead), .moveStart(moveStart), .targetPosition(targetPosition),
  .moveDir(moveDir), .useOtpParams(useOtpParams), .actualPositionClear(actualPositionClear),
  .stopState(stopState), .sleepState(sleepState), .regRdata(regRdata));
`default_nettype wire
